// ==== hdl/ahb_reg_port.sv ====
// AHB-Lite slave front end with one wait state
`timescale 1ns/1ps
`include "gpio_map.svh"
module ahb_reg_port (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output gpio_pkg::bus_cmd_s       cmd,
  output logic                     wr_en,
  output logic                     rd_en
);
  gpio_pkg::bus_state_e state;
  gpio_pkg::bus_state_e next_state;
  wire taken = hsel & htrans[1] & hready;

  // Sequencer: address taken, one wait cycle, then done
  always_comb begin
    case (state)
      gpio_pkg::ST_IDLE: next_state = taken ? gpio_pkg::ST_WAIT : gpio_pkg::ST_IDLE;
      gpio_pkg::ST_WAIT: next_state = gpio_pkg::ST_DONE;
      gpio_pkg::ST_DONE: next_state = taken ? gpio_pkg::ST_WAIT : gpio_pkg::ST_IDLE;
      default:           next_state = gpio_pkg::ST_IDLE;
    endcase
  end

  // Strobes in the wait cycle, when hwdata stands
  assign wr_en = (state == gpio_pkg::ST_WAIT) & cmd.write;
  assign rd_en = (state == gpio_pkg::ST_WAIT) & ~cmd.write;

  // State, latched command and registered ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= gpio_pkg::ST_IDLE;
      cmd       <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      state     <= next_state;
      hreadyout <= (next_state != gpio_pkg::ST_WAIT);
      hresp     <= 1'b0; // Always OKAY
      if (taken) begin
        cmd <= '{addr: haddr[`ADDR_W-1:0], write: hwrite};
      end
    end
  end

  sequence s_taken;
    taken;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_taken |=> s_one_wait)
    else $error("slave did not answer after exactly one wait state");
endmodule : ahb_reg_port

// ==== hdl/gpio_map.svh ====
// Register offsets, field positions and fixed defaults of the pin bank
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
`define OFS_UPPER_CFG   12'h01C
`define OFS_WAKE        12'h020
`define OFS_IRQ_STATUS  12'h100
`define OFS_IRQ_CLEAR   12'h104
`define OFS_IRQ_ENABLE  12'h108
`define ADDR_W          12
`define FN_LSB          24
`define BUF_LSB         16
`define DIR_LSB         8
`define DATA_LSB        0
`define POL_LSB         16
`define WAKE_LSB        0
`define UPPER_LSB       4
`define FIXED_FN        8'hFF
`define FIXED_OTHER     8'h00
`define FIXED_FN_UPPER  4'hF
`endif

// ==== hdl/gpio_pkg.sv ====
// Types shared by the pin bank modules
`include "gpio_map.svh"
package gpio_pkg;
  // One loaded image, one byte per field, pin n on bit n
  typedef struct packed {
    logic [7:0] fn;
    logic [7:0] buffer;
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] wake_en;
    logic [7:0] pol;
  } image_s;

  // Live configuration, upper pins on bits 3:0 of fn, buffer, dir and data; wake_en and pol keep pin n on bit n
  typedef struct packed {
    logic [3:0] fn;
    logic [3:0] buffer;
    logic [3:0] dir;
    logic [3:0] data;
    logic [7:0] wake_en;
    logic [7:0] pol;
  } config_s;

  // Latched address phase
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic               write;
  } bus_cmd_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h4
  } bus_state_e;

  // Image to live fields: upper nibble for pins 4..7, wake_en and pol copied whole
  function automatic config_s to_config(input image_s img);
    config_s c;
    c.fn      = img.fn[`UPPER_LSB +: 4];
    c.buffer  = img.buffer[`UPPER_LSB +: 4];
    c.dir     = img.dir[`UPPER_LSB +: 4];
    c.data    = img.data[`UPPER_LSB +: 4];
    c.wake_en = img.wake_en;
    c.pol     = img.pol;
    return c;
  endfunction : to_config
endpackage : gpio_pkg

// ==== hdl/gpio_upper_config_and_wake.sv ====
// Upper pin configuration, wake mask and polarity with AHB-Lite access
`timescale 1ns/1ps
`include "gpio_map.svh"
module gpio_upper_config_and_wake (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic [7:0]       pin_in,
  output logic [3:0]            pin_out,
  output logic [3:0]            pin_oe,
  input  wire logic [3:0]       alt_out,
  input  wire logic [3:0]       alt_oe,
  input  wire logic [3:0]       lower_fn,
  input  wire logic [3:0]       lower_dir,
  input  wire logic             image_load,
  input  wire logic             eeprom_present,
  input  wire logic             otp_programmed,
  input  wire gpio_pkg::image_s eeprom_image,
  input  wire gpio_pkg::image_s otp_image,
  input  wire logic             usb_reset,
  input  wire logic             lite_reset,
  input  wire logic             rst_protect,
  output logic                  wake_out,
  output logic                  irq
);
  gpio_pkg::config_s  cfg;
  gpio_pkg::config_s  next_cfg;
  gpio_pkg::image_s   shadow;
  gpio_pkg::image_s   fixed_image;
  gpio_pkg::image_s   picked_image;
  gpio_pkg::bus_cmd_s cmd;
  logic               wr_en;
  logic               rd_en;
  logic [7:0]         irq_status;
  logic [7:0]         irq_enable;
  logic [7:0]         event_pulse;
  logic [7:0]         next_status;
  logic [7:0]         eligible;
  logic               wake;
  logic [31:0]        cfg_word;
  logic [31:0]        wake_word;
  logic [31:0]        read_word;
  logic [3:0]         next_out;
  logic [3:0]         next_oe;

  // Bus front end; hsize is always a word here
  ahb_reg_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cmd       (cmd),
    .wr_en     (wr_en),
    .rd_en     (rd_en)
  );

  // Match of the latched address against one register offset
  function automatic logic addr_is(input logic [`ADDR_W-1:0] a,
                                   input logic [`ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : addr_is

  // Address decode
  wire wr_cfg  = wr_en & addr_is(cmd.addr, `OFS_UPPER_CFG);
  wire wr_wake = wr_en & addr_is(cmd.addr, `OFS_WAKE);
  wire wr_clr  = wr_en & addr_is(cmd.addr, `OFS_IRQ_CLEAR);
  wire wr_ien  = wr_en & addr_is(cmd.addr, `OFS_IRQ_ENABLE);
  wire reload  = (usb_reset | lite_reset) & ~rst_protect;

  // Image source: EEPROM, else OTP, else fixed values
  assign fixed_image = '{fn: `FIXED_FN, buffer: `FIXED_OTHER, dir: `FIXED_OTHER,
                         data: `FIXED_OTHER, wake_en: `FIXED_OTHER, pol: `FIXED_OTHER};
  assign picked_image = eeprom_present ? eeprom_image :
                        otp_programmed ? otp_image : fixed_image;

  // Next configuration: image load, then reset reload, then software
  always_comb begin
    next_cfg = cfg;
    if (image_load) begin
      next_cfg = gpio_pkg::to_config(picked_image);
    end else if (reload) begin
      next_cfg = gpio_pkg::to_config(shadow);
    end else if (wr_cfg) begin
      next_cfg.fn     = hwdata[`FN_LSB +: 4];
      next_cfg.buffer = hwdata[`BUF_LSB +: 4];
      next_cfg.dir    = hwdata[`DIR_LSB +: 4];
      next_cfg.data   = hwdata[`DATA_LSB +: 4];
    end else if (wr_wake) begin
      next_cfg.wake_en = hwdata[`WAKE_LSB +: 8];
      next_cfg.pol     = hwdata[`POL_LSB +: 8];
    end
  end

  // Read words; reserved bits stay zero
  assign cfg_word  = ({28'h0000000, cfg.fn} << `FN_LSB)
                   | ({28'h0000000, cfg.buffer} << `BUF_LSB)
                   | ({28'h0000000, cfg.dir} << `DIR_LSB)
                   | ({28'h0000000, pin_in[`UPPER_LSB +: 4]} << `DATA_LSB);
  assign wake_word = ({24'h000000, cfg.pol} << `POL_LSB)
                   | ({24'h000000, cfg.wake_en} << `WAKE_LSB);
  assign read_word = addr_is(cmd.addr, `OFS_UPPER_CFG)  ? cfg_word :
                     addr_is(cmd.addr, `OFS_WAKE)       ? wake_word :
                     addr_is(cmd.addr, `OFS_IRQ_STATUS) ? {24'h000000, irq_status} :
                     addr_is(cmd.addr, `OFS_IRQ_ENABLE) ? {24'h000000, irq_enable} :
                     32'h00000000;

  // Pad drive: alternate function or plain pin with buffer type
  assign next_oe  = (cfg.fn & alt_oe) |
                    (~cfg.fn & cfg.dir & (cfg.buffer | ~cfg.data));
  assign next_out = (cfg.fn & alt_out) | (~cfg.fn & cfg.data & cfg.buffer);

  // Plain inputs only, lower pins from their own configuration
  assign eligible = ~{cfg.fn, lower_fn} & ~{cfg.dir, lower_dir};

  wake_detect #(
    .N (8)
  ) u_wake (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .level       (pin_in),
    .eligible    (eligible),
    .pol         (cfg.pol),
    .wake_en     (cfg.wake_en),
    .event_pulse (event_pulse),
    .wake        (wake)
  );

  // Sticky status; a new event wins over a clear
  assign next_status = (irq_status & ~(wr_clr ? hwdata[7:0] : 8'h00)) | event_pulse;

  // Configuration and shadow image
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg    <= '{fn: `FIXED_FN_UPPER, buffer: '0, dir: '0, data: '0,
                  wake_en: `FIXED_OTHER, pol: `FIXED_OTHER};
      shadow <= '{fn: `FIXED_FN, buffer: `FIXED_OTHER, dir: `FIXED_OTHER,
                  data: `FIXED_OTHER, wake_en: `FIXED_OTHER, pol: `FIXED_OTHER};
    end else begin
      cfg <= next_cfg;
      if (image_load) begin
        shadow <= picked_image;
      end
    end
  end

  // Registered outputs, status and enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= 32'h00000000;
      pin_out    <= 4'h0;
      pin_oe     <= 4'h0;
      wake_out   <= 1'b0;
      irq        <= 1'b0;
      irq_status <= 8'h00;
      irq_enable <= 8'h00;
    end else begin
      if (rd_en) begin
        hrdata <= read_word;
      end
      pin_out    <= next_out;
      pin_oe     <= next_oe;
      wake_out   <= wake;
      irq_status <= next_status;
      irq        <= |(irq_status & irq_enable);
      if (wr_ien) begin
        irq_enable <= hwdata[7:0];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_cfg;
    rd_en && addr_is(cmd.addr, `OFS_UPPER_CFG);
  endsequence

  // Steps that change the configuration, in priority order
  sequence s_image_load;
    image_load;
  endsequence
  sequence s_reload;
    reload && !image_load;
  endsequence
  sequence s_cfg_write;
    wr_cfg && !image_load && !reload;
  endsequence
  sequence s_wake_write;
    wr_wake && !image_load && !reload;
  endsequence

  // Plain input pins stay undriven
  chk_input_no_drive: assert property (
    1 |=> (pin_oe & ~$past(cfg.fn) & ~$past(cfg.dir)) == 4'h0)
    else $error("plain input pin is being driven");

  // Plain push-pull outputs always drive
  chk_push_pull_drive: assert property (
    1 |=> (~pin_oe & $past(~cfg.fn & cfg.dir & cfg.buffer)) == 4'h0)
    else $error("push-pull output pin not driven");

  // Open-drain pins only pull low
  chk_open_drain_low: assert property (
    1 |=> (pin_oe & pin_out & ~$past(cfg.fn) & ~$past(cfg.buffer)) == 4'h0)
    else $error("open-drain pin driven high");

  // Driven push-pull pins carry their data bit
  chk_pin_data_drive: assert property (
    1 |=> ((pin_out ^ $past(cfg.data)) & pin_oe & $past(~cfg.fn & cfg.buffer)) == 4'h0)
    else $error("push-pull pin does not carry its data bit");

  // Alternate pins follow the alternate drive
  chk_alt_follows: assert property (
    1 |=> ((pin_oe ^ $past(alt_oe)) & $past(cfg.fn)) == 4'h0)
    else $error("alternate pin does not follow its function enable");

  // Data read returns the pin level of the wait cycle
  chk_data_read_level: assert property (
    s_rd_cfg |=> hrdata[3:0] == $past(pin_in[7:4]))
    else $error("data read does not return pin level");

  // Reserved bits of the configuration word
  chk_reserved_zero: assert property (
    s_rd_cfg |=> (hrdata & 32'hF0F0F0F0) == 32'h00000000)
    else $error("reserved bits read nonzero");

  // Wake only from enabled plain inputs
  chk_wake_gated: assert property (
    wake_out |-> $past(|(cfg.wake_en & eligible), 2))
    else $error("wake from disabled, output or alternate pin");

  // Events only from plain input pins
  chk_event_eligible: assert property (
    (event_pulse & ~eligible) == 8'h00)
    else $error("event raised by an output or alternate pin");

  // Image load applies the picked image
  chk_image_applied: assert property (
    s_image_load |=> cfg == gpio_pkg::to_config($past(picked_image)))
    else $error("loaded image not applied");

  // Image load keeps the picked image for reloads
  chk_shadow_capture: assert property (
    s_image_load |=> shadow == $past(picked_image))
    else $error("loaded image not kept for reloads");

  // Unprotected reset restores the kept image
  chk_reset_reload: assert property (
    s_reload |=> cfg == gpio_pkg::to_config($past(shadow)))
    else $error("reset did not restore image values");

  // Protected fields ignore resets
  chk_protect_hold: assert property (
    rst_protect && (usb_reset || lite_reset) && !image_load && !wr_en |=> $stable(cfg))
    else $error("protected fields changed on reset");

  // Fixed values without any image
  chk_fixed_default: assert property (
    image_load && !eeprom_present && !otp_programmed
    |=> cfg.fn == `FIXED_FN_UPPER && cfg.wake_en == 8'h00 && cfg.pol == 8'h00)
    else $error("fixed defaults not applied");

  // Software write of function and direction
  chk_cfg_write: assert property (
    s_cfg_write |=> cfg.fn == $past(hwdata[`FN_LSB +: 4])
                    && cfg.dir == $past(hwdata[`DIR_LSB +: 4]))
    else $error("function or direction write lost");

  // Software write of buffer type and data
  chk_buf_data_write: assert property (
    s_cfg_write |=> cfg.buffer == $past(hwdata[`BUF_LSB +: 4])
                    && cfg.data == $past(hwdata[`DATA_LSB +: 4]))
    else $error("buffer type or data write lost");

  // Software write of wake mask and polarity
  chk_wake_write: assert property (
    s_wake_write |=> cfg.wake_en == $past(hwdata[`WAKE_LSB +: 8])
                     && cfg.pol == $past(hwdata[`POL_LSB +: 8]))
    else $error("wake mask or polarity write lost");

  // Clear drops every written bit without a new event
  chk_status_clear: assert property (
    wr_clr |=> (irq_status & $past(hwdata[7:0] & ~event_pulse)) == 8'h00)
    else $error("status bit survived its clear");

  // A new event wins over a clear
  chk_status_set_wins: assert property (
    |event_pulse |=> (irq_status & $past(event_pulse)) == $past(event_pulse))
    else $error("event lost against a clear");

  // Interrupt level follows enabled status
  chk_irq_level: assert property (
    1 |=> irq == $past(|(irq_status & irq_enable)))
    else $error("interrupt level does not follow enabled status");
endmodule : gpio_upper_config_and_wake

// ==== hdl/wake_detect.sv ====
// Per-pin wake and event detection
`timescale 1ns/1ps
module wake_detect #(
  parameter int N = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] eligible,
  input  wire logic [N-1:0] pol,
  input  wire logic [N-1:0] wake_en,
  output logic [N-1:0]      event_pulse,
  output logic              wake
);
  logic [N-1:0] active;
  logic [N-1:0] active_q;

  // Active level per pin, only on plain input pins
  for (genvar i = 0; i < N; i++) begin : g_pin
    assign active[i]      = eligible[i] & (level[i] == pol[i]);
    assign event_pulse[i] = active[i] & ~active_q[i];
  end

  // Previous active state and masked wake request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q <= '0;
      wake     <= 1'b0;
    end else begin
      active_q <= active;
      wake     <= |(active & wake_en);
    end
  end

  chk_wake_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
    wake |-> $past(|(eligible & wake_en & ~(level ^ pol))))
    else $error("wake raised without a matching enabled input pin");
endmodule : wake_detect

// ==== tb/pin_bank_model.sv ====
// Pads of the upper pin bank: bank drive, external levels, released lines
`timescale 1ns/1ps
module pin_bank_model (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic [7:0]      pin_in
);
  // Released pads fall back to the external pull level, driven pads follow the bank
  assign pin_in[3:0] = ext_level[3:0];
  assign pin_in[7:4] = (pin_oe & pin_out) | (~pin_oe & ext_level[7:4]);
endmodule : pin_bank_model

// ==== tb/tb_top.sv ====
// Self-checking bench of the upper pin configuration and wake block
`timescale 1ns/1ps
`include "gpio_map.svh"
module tb_top;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [31:0]       hwdata = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  wire               hready;
  logic [31:0]       hrdata;
  logic              hresp;
  logic [7:0]        pin_in;
  logic [3:0]        pin_out, pin_oe;
  logic [3:0]        alt_out = 4'h0, alt_oe = 4'h0, lower_fn = 4'h0, lower_dir = 4'h0;
  logic              image_load = 1'b0, usb_reset = 1'b0, lite_reset = 1'b0;
  logic              eeprom_present = 1'b0, otp_programmed = 1'b0, rst_protect = 1'b0;
  gpio_pkg::image_s  eeprom_image = {8'h5A, 8'h3C, 8'h0F, 8'h0F, 8'hC3, 8'h96};
  gpio_pkg::image_s  otp_image = {8'h3C, 8'hA5, 8'h05, 8'h00, 8'h18, 8'h24};
  logic [7:0]        ext_level = 8'hC0;
  logic              wake_out, irq;
  int                err_count = 0;
  int                n_compared = 0;

  // Free-running bus clock
  always #5 hclk = ~hclk;

  gpio_upper_config_and_wake DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .lower_fn(lower_fn), .lower_dir(lower_dir), .image_load(image_load),
    .eeprom_present(eeprom_present), .otp_programmed(otp_programmed),
    .eeprom_image(eeprom_image), .otp_image(otp_image), .usb_reset(usb_reset),
    .lite_reset(lite_reset), .rst_protect(rst_protect), .wake_out(wake_out), .irq(irq));

  pin_bank_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
                       .pin_in(pin_in));

  // Verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED hready expected 1 seen %b", hready);
      results();
    end
  endtask : wait_rdy

  // One single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    chk(nm, exp, rd);
  endtask : rdchk

  // Pulse select: 0 image load, 1 usb reset, 2 lite reset
  task automatic pulse(input int w);
    @(posedge hclk);
    {lite_reset, usb_reset, image_load} <= 3'(1 << w);
    @(posedge hclk);
    {lite_reset, usb_reset, image_load} <= 3'h0;
  endtask : pulse

  // Set pad levels and lower pin setup, let detection settle, check wake
  task automatic wk(input logic [7:0] e, input logic [3:0] f, input logic [3:0] d,
                    input logic x, input string nm);
    @(posedge hclk);
    ext_level <= e;
    lower_fn <= f;
    lower_dir <= d;
    repeat (4) @(posedge hclk);
    chk(nm, {31'h0, x}, {31'h0, wake_out});
  endtask : wk

  task automatic imgchk(input gpio_pkg::image_s im);
    rdchk("cfg image", `OFS_UPPER_CFG, {4'h0, im.fn[7:4], 4'h0, im.buffer[7:4], 4'h0,
          im.dir[7:4], 8'h0F});
    rdchk("wake image", `OFS_WAKE, {8'h0, im.pol, 8'h0, im.wake_en});
  endtask : imgchk

  // Main sequence
  initial begin
    gpio_pkg::image_s exp;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("cfg reset", `OFS_UPPER_CFG, 32'h0F00000C);
    rdchk("wake reset", `OFS_WAKE, 32'h0);
    wr(`OFS_UPPER_CFG, 32'hF0F5F3F1);
    rdchk("cfg fields", `OFS_UPPER_CFG, 32'h0005030D);
    chk("oe drive", 32'h3, {28'h0, pin_oe});
    chk("out drive", 32'h1, {28'h0, pin_out & pin_oe});
    wr(`OFS_UPPER_CFG, 32'h00050303);
    repeat (2) @(posedge hclk);
    chk("open drain", 32'h1, {28'h0, pin_oe});
    alt_oe <= 4'hA;
    alt_out <= 4'h6;
    wr(`OFS_UPPER_CFG, 32'h0F050303);
    repeat (2) @(posedge hclk);
    chk("alt pass", 32'hA6, {24'h0, pin_oe, pin_out});
    alt_oe <= 4'h0;
    wr(`OFS_WAKE, 32'hFFFFFFFF);
    rdchk("wake fields", `OFS_WAKE, 32'h00FF00FF);
    wr(12'h040, 32'hFFFFFFFF);
    rdchk("unmapped", 12'h040, 32'h0);
    ext_level <= 8'hF0;
    wr(`OFS_WAKE, 32'h000F0081);
    wr(`OFS_UPPER_CFG, 32'h0);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    wr(`OFS_IRQ_CLEAR, 32'hFF);
    wk(8'hF2, 4'h0, 4'h0, 1'b0, "wake masked");
    rdchk("status high pol", `OFS_IRQ_STATUS, 32'h2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_ENABLE, 32'h2);
    rdchk("irq enable", `OFS_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk("status cleared", `OFS_IRQ_STATUS, 32'h0);
    rdchk("clear reads zero", `OFS_IRQ_CLEAR, 32'h0);
    wk(8'hF3, 4'h0, 4'h0, 1'b1, "wake pin0");
    wk(8'hF3, 4'h1, 4'h0, 1'b0, "wake alt fn");
    wk(8'hF3, 4'h0, 4'h1, 1'b0, "wake output");
    wk(8'h72, 4'h0, 4'h0, 1'b1, "wake low pol");
    wr(`OFS_UPPER_CFG, 32'h00000800);
    wk(8'h72, 4'h0, 4'h0, 1'b0, "wake upper out");
    ext_level <= 8'hF0;
    // Image sources in turn, then protected and unprotected reloads
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      eeprom_present <= (k == 0);
      otp_programmed <= (k == 1);
      pulse(0);
      exp = (k == 0) ? eeprom_image : (k == 1) ? otp_image : {8'hFF, 40'h0};
      imgchk(exp);
      wr(`OFS_UPPER_CFG, 32'h0C0C0000);
      wr(`OFS_WAKE, 32'h00110011);
      @(posedge hclk);
      rst_protect <= 1'b1;
      pulse(1 + k % 2);
      rdchk("protected", `OFS_UPPER_CFG, 32'h0C0C000F);
      @(posedge hclk);
      rst_protect <= 1'b0;
      pulse(2 - k % 2);
      imgchk(exp);
    end
    results();
  end
endmodule : tb_top
